// ### pkg/ccr_pkg.sv
// Shared constants and types for the codec configuration register bank
package ccr_pkg;

  // ==========================================================
  // Address pointer
  localparam int unsigned PTR_W      = 7;
  localparam logic [6:0]  PTR_RESET  = 7'h01;
  localparam int unsigned PTR_AUTO_BIT = 7;
  localparam logic        AUTO_RESET = 1'b1;

  // ==========================================================
  // Register addresses
  localparam logic [6:0] ADDR_ID   = 7'h01;
  localparam logic [6:0] ADDR_PWR  = 7'h02;
  localparam logic [6:0] ADDR_MODE = 7'h03;
  localparam logic [6:0] ADDR_FMT  = 7'h04;
  localparam logic [6:0] ADDR_MISC = 7'h05;

  // ==========================================================
  // Reset values and writable bit masks
  localparam logic [7:0] PWR_RESET  = 8'h01;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] FMT_RESET  = 8'h40;
  localparam logic [7:0] MISC_RESET = 8'h03;
  localparam logic [7:0] PWR_MASK   = 8'h7F;
  localparam logic [7:0] MODE_MASK  = 8'hF6;
  localparam logic [7:0] FMT_MASK   = 8'hFD;
  localparam logic [7:0] MISC_MASK  = 8'hDF;

  // ==========================================================
  // Field positions (low bit of each field)
  localparam int unsigned PWR_PLL       = 6;
  localparam int unsigned PWR_ADC       = 5;
  localparam int unsigned PWR_PAIR_LO   = 1;
  localparam int unsigned PWR_GLOBAL    = 0;
  localparam int unsigned MODE_DAC_SPD  = 6;
  localparam int unsigned MODE_ADC_SPD  = 4;
  localparam int unsigned MODE_CAP_CLK  = 2;
  localparam int unsigned MODE_DEEMPH   = 1;
  localparam int unsigned FMT_SERIAL    = 6;
  localparam int unsigned FMT_ADC_SL    = 4;
  localparam int unsigned FMT_DAC_SL    = 2;
  localparam int unsigned FMT_RJ16      = 0;
  localparam int unsigned MISC_EXT_CLK  = 7;
  localparam int unsigned MISC_HIZ      = 6;
  localparam int unsigned MISC_FREEZE   = 4;
  localparam int unsigned MISC_ROLLOFF  = 3;
  localparam int unsigned MISC_HPF      = 2;
  localparam int unsigned MISC_PLAY_MST = 1;
  localparam int unsigned MISC_CAP_MST  = 0;

  // ==========================================================
  // Encodings
  localparam logic [1:0] SL_FOLLOW = 2'h0;
  localparam logic [1:0] SL_ONE    = 2'h1;
  localparam logic [1:0] SL_TWO    = 2'h2;
  localparam logic [1:0] SER_LJ    = 2'h0;
  localparam logic [1:0] SER_I2S   = 2'h1;
  localparam logic [1:0] SER_RJ    = 2'h2;
  localparam logic [1:0] RATE_NONE = 2'h0;
  localparam logic [4:0] LRCK_BIT_LAST = 5'h1F;

  typedef enum logic [2:0] {
    FRAME_LJ   = 3'h0,
    FRAME_I2S  = 3'h1,
    FRAME_RJ   = 3'h2,
    FRAME_OL1  = 3'h3,
    FRAME_OL2  = 3'h4,
    FRAME_RSVD = 3'h7
  } ccr_frame_t;

  typedef enum logic [1:0] {
    CP_PTR  = 2'b01,
    CP_DATA = 2'b10
  } ccr_cp_state_t;

endpackage : ccr_pkg

// ### pkg/ccr_port_if.sv
// Serial port clock bundle between the register bank and a clock divider
`timescale 1ns/10ps
interface ccr_port_if;
  logic bclk_o;
  logic bclk_oe;
  logic lrck_o;
  logic lrck_oe;
  logic bclk_in;
  logic lrck_in;
  logic bclk_eff;
  logic lrck_eff;

  modport div (output bclk_o, bclk_oe, lrck_o, lrck_oe, bclk_eff, lrck_eff, input bclk_in, lrck_in);
  modport top (input bclk_o, bclk_oe, lrck_o, lrck_oe, bclk_eff, lrck_eff, output bclk_in, lrck_in);
endinterface : ccr_port_if

// ### hw/ccr_cfg_byte.sv
// One control byte with reset value and writable-bit mask
`timescale 1ns/10ps
module ccr_cfg_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);
  // ==========================================================
  // Storage
  logic [7:0] q_r;

  // Masked bits keep their reset value, so reserved bits stay zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= RESET_VAL;
    else if (we)
      q_r <= (q_r & ~WR_MASK) | (wdata & WR_MASK);
  end

  assign q = q_r;
endmodule : ccr_cfg_byte

// ### hw/ccr_clk_div.sv
// Bit and frame clock generator for one serial port
`timescale 1ns/10ps
module ccr_clk_div #(
  parameter logic [3:0] HALF_BASE = 4'h8
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       master,
  input  wire logic [1:0] speed,
  ccr_port_if.div         port
);
  import ccr_pkg::*;

  // ==========================================================
  // Divider state
  logic [3:0] half;
  logic [3:0] cnt_r;
  logic [4:0] bit_cnt_r;
  logic       bclk_r;
  logic       lrck_r;
  logic       oe_r;
  logic       wrap;

  // Faster rate ranges halve the bit clock period
  assign half = HALF_BASE >> speed;
  assign wrap = master && (cnt_r == half - 4'h1);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 4'h0;
    else if (!master || wrap)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      bclk_r <= 1'b0;
    else if (!master)
      bclk_r <= 1'b0;
    else if (wrap)
      bclk_r <= ~bclk_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_r <= 5'h00;
      lrck_r    <= 1'b0;
    end
    else if (!master)
    begin
      bit_cnt_r <= 5'h00;
      lrck_r    <= 1'b0;
    end
    else if (wrap && bclk_r)
    begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      if (bit_cnt_r == LRCK_BIT_LAST)
        lrck_r <= ~lrck_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_r <= 1'b0;
    else
      oe_r <= master;
  end

  assign port.bclk_o   = bclk_r;
  assign port.lrck_o   = lrck_r;
  assign port.bclk_oe  = oe_r;
  assign port.lrck_oe  = oe_r;
  assign port.bclk_eff = oe_r ? bclk_r : port.bclk_in;
  assign port.lrck_eff = oe_r ? lrck_r : port.lrck_in;
endmodule : ccr_clk_div

// ### hw/ccr_regs.sv
// Codec configuration register bank behind the control port
`timescale 1ns/10ps
module ccr_regs #(
  parameter logic [3:0] PART_CODE = 4'h5,  // Arbitrary value
  parameter logic [3:0] REV_CODE  = 4'h2,  // Arbitrary value
  parameter logic [3:0] BCLK_HALF_BASE = 4'h8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 cp_start,
  input  wire logic                 cp_wr,
  input  wire logic [7:0]           cp_wdata,
  input  wire logic                 cp_rd,
  output logic      [7:0]           cp_rdata,
  output logic                      cp_rvalid,
  input  wire logic [1:0]           detected_rate,
  input  wire logic                 force_lock,
  input  wire logic [1:0]           deemphasis_rate,
  input  wire logic                 recovered_clk_in,
  input  wire logic                 playback_bclk_in,
  input  wire logic                 playback_lrck_in,
  input  wire logic                 capture_bclk_in,
  input  wire logic                 capture_lrck_in,
  output logic                      playback_bclk_o,
  output logic                      playback_bclk_oe,
  output logic                      playback_lrck_o,
  output logic                      playback_lrck_oe,
  output logic                      capture_bclk_o,
  output logic                      capture_bclk_oe,
  output logic                      capture_lrck_o,
  output logic                      capture_lrck_oe,
  output logic                      capture_shift_bclk,
  output logic                      capture_shift_lrck,
  output logic                      external_adc_inputs_bclk,
  output logic                      recovered_clock_out,
  output logic                      recovered_clock_out_oe,
  output logic                      pll_hold,
  output logic                      adc_hold,
  output logic      [3:0]           pair_hold,
  output logic                      global_sleep,
  output logic      [1:0]           dac_port_speed,
  output logic      [1:0]           adc_port_speed,
  output logic                      deemph_active,
  output logic      [1:0]           deemph_rate_sel,
  output ccr_pkg::ccr_frame_t       playback_framing,
  output ccr_pkg::ccr_frame_t       capture_framing,
  output logic                      playback_rj16,
  output logic                      capture_rj16,
  output logic                      rolloff_select,
  output logic                      highpass_hold,
  output logic                      update_hold,
  output logic                      update_apply
);
  import ccr_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ==========================================================
  // Control port sequencing
  ccr_cp_state_t    state_r;
  logic [PTR_W-1:0] ptr_r;
  logic             auto_r;
  logic             ptr_phase;
  logic             ptr_load;
  logic             data_wr;
  logic             data_rd;
  logic             access;

  // A start marks the next written byte as the pointer byte
  assign ptr_phase = cp_start || (state_r == CP_PTR);
  assign ptr_load  = cp_wr && ptr_phase;
  assign data_wr   = cp_wr && !ptr_phase;
  assign data_rd   = cp_rd && !cp_wr;
  assign access    = data_wr || data_rd;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      state_r <= CP_PTR;
    else
    begin
      case (state_r)
        CP_PTR:  if (ptr_load) state_r <= CP_DATA;
        CP_DATA: if (cp_start && !cp_wr) state_r <= CP_PTR;
        default: state_r <= CP_PTR;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ptr_r  <= PTR_RESET;
      auto_r <= AUTO_RESET;
    end
    else if (ptr_load)
    begin
      ptr_r  <= cp_wdata[PTR_W-1:0];
      auto_r <= cp_wdata[PTR_AUTO_BIT];
    end
    else if (access && auto_r)
      ptr_r <= ptr_r + 7'h01;
  end

  // ==========================================================
  // Register storage
  logic [7:0] pwr_q;
  logic [7:0] mode_q;
  logic [7:0] fmt_q;
  logic [7:0] misc_q;

  // Identity and unmapped addresses have no write enable
  ccr_cfg_byte #(.RESET_VAL(PWR_RESET), .WR_MASK(PWR_MASK)) u_pwr (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .we      (data_wr && (ptr_r == ADDR_PWR)),
    .wdata   (cp_wdata),
    .q       (pwr_q)
  );

  ccr_cfg_byte #(.RESET_VAL(MODE_RESET), .WR_MASK(MODE_MASK)) u_mode (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .we      (data_wr && (ptr_r == ADDR_MODE)),
    .wdata   (cp_wdata),
    .q       (mode_q)
  );

  ccr_cfg_byte #(.RESET_VAL(FMT_RESET), .WR_MASK(FMT_MASK)) u_fmt (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .we      (data_wr && (ptr_r == ADDR_FMT)),
    .wdata   (cp_wdata),
    .q       (fmt_q)
  );

  ccr_cfg_byte #(.RESET_VAL(MISC_RESET), .WR_MASK(MISC_MASK)) u_misc (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .we      (data_wr && (ptr_r == ADDR_MISC)),
    .wdata   (cp_wdata),
    .q       (misc_q)
  );

  // ==========================================================
  // Read path
  logic [7:0] rd_byte;

  always_comb
  begin
    case (ptr_r)
      ADDR_ID:   rd_byte = {PART_CODE, REV_CODE};
      ADDR_PWR:  rd_byte = pwr_q;
      ADDR_MODE: rd_byte = mode_q;
      ADDR_FMT:  rd_byte = fmt_q;
      ADDR_MISC: rd_byte = misc_q;
      default:   rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cp_rdata  <= 8'h00;
      cp_rvalid <= 1'b0;
    end
    else
    begin
      cp_rvalid <= data_rd;
      if (data_rd)
        cp_rdata <= rd_byte;
    end
  end

  // ==========================================================
  // Power holds
  // Global sleep forces every block down but leaves the registers alone
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pll_hold     <= 1'b1;
      adc_hold     <= 1'b1;
      pair_hold    <= 4'hF;
      global_sleep <= 1'b1;
    end
    else
    begin
      pll_hold     <= pwr_q[PWR_PLL] || pwr_q[PWR_GLOBAL];
      adc_hold     <= pwr_q[PWR_ADC] || pwr_q[PWR_GLOBAL];
      pair_hold    <= pwr_q[PWR_PAIR_LO +: 4] | {4{pwr_q[PWR_GLOBAL]}};
      global_sleep <= pwr_q[PWR_GLOBAL];
    end
  end

  // ==========================================================
  // Rate ranges and de-emphasis
  logic [1:0] rate_now;

  // Forced lock disables detection, so the host supplies the rate
  assign rate_now = force_lock ? deemphasis_rate : detected_rate;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dac_port_speed  <= 2'h0;
      adc_port_speed  <= 2'h0;
      deemph_active   <= 1'b0;
      deemph_rate_sel <= RATE_NONE;
    end
    else
    begin
      dac_port_speed  <= mode_q[MODE_DAC_SPD +: 2];
      adc_port_speed  <= mode_q[MODE_ADC_SPD +: 2];
      deemph_active   <= mode_q[MODE_DEEMPH] && (rate_now != RATE_NONE);
      deemph_rate_sel <= mode_q[MODE_DEEMPH] ? rate_now : RATE_NONE;
    end
  end

  // ==========================================================
  // Framing
  function automatic ccr_frame_t frame_of(input logic [1:0] sl, input logic [1:0] ser);
    ccr_frame_t f;
    f = FRAME_RSVD;
    if (sl == SL_ONE)
      f = FRAME_OL1;
    else if (sl == SL_TWO)
      f = FRAME_OL2;
    else if (sl == SL_FOLLOW)
    begin
      if (ser == SER_LJ)
        f = FRAME_LJ;
      else if (ser == SER_I2S)
        f = FRAME_I2S;
      else if (ser == SER_RJ)
        f = FRAME_RJ;
    end
    return f;
  endfunction : frame_of

  ccr_frame_t play_frame;
  ccr_frame_t cap_frame;

  assign play_frame = frame_of(fmt_q[FMT_DAC_SL +: 2], fmt_q[FMT_SERIAL +: 2]);
  assign cap_frame  = frame_of(fmt_q[FMT_ADC_SL +: 2], fmt_q[FMT_SERIAL +: 2]);

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      playback_framing <= FRAME_I2S;
      capture_framing  <= FRAME_I2S;
      playback_rj16    <= 1'b0;
      capture_rj16     <= 1'b0;
    end
    else
    begin
      playback_framing <= play_frame;
      capture_framing  <= cap_frame;
      playback_rj16    <= fmt_q[FMT_RJ16] && (play_frame == FRAME_RJ);
      capture_rj16     <= fmt_q[FMT_RJ16] && (cap_frame == FRAME_RJ);
    end
  end

  // ==========================================================
  // Serial port clocks
  ccr_port_if play_if ();
  ccr_port_if cap_if ();

  assign play_if.bclk_in = playback_bclk_in;
  assign play_if.lrck_in = playback_lrck_in;
  assign cap_if.bclk_in  = capture_bclk_in;
  assign cap_if.lrck_in  = capture_lrck_in;

  ccr_clk_div #(.HALF_BASE(BCLK_HALF_BASE)) u_play_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .master  (misc_q[MISC_PLAY_MST]),
    .speed   (mode_q[MODE_DAC_SPD +: 2]),
    .port    (play_if)
  );

  ccr_clk_div #(.HALF_BASE(BCLK_HALF_BASE)) u_cap_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .master  (misc_q[MISC_CAP_MST]),
    .speed   (mode_q[MODE_ADC_SPD +: 2]),
    .port    (cap_if)
  );

  assign playback_bclk_o  = play_if.bclk_o;
  assign playback_bclk_oe = play_if.bclk_oe;
  assign playback_lrck_o  = play_if.lrck_o;
  assign playback_lrck_oe = play_if.lrck_oe;
  assign capture_bclk_o   = cap_if.bclk_o;
  assign capture_bclk_oe  = cap_if.bclk_oe;
  assign capture_lrck_o   = cap_if.lrck_o;
  assign capture_lrck_oe  = cap_if.lrck_oe;

  // Slave clocks pass one flop, so they lag the pins by a cycle
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      capture_shift_bclk       <= 1'b0;
      capture_shift_lrck       <= 1'b0;
      external_adc_inputs_bclk <= 1'b0;
    end
    else
    begin
      capture_shift_bclk <= mode_q[MODE_CAP_CLK] ? cap_if.bclk_eff : play_if.bclk_eff;
      capture_shift_lrck <= mode_q[MODE_CAP_CLK] ? cap_if.lrck_eff : play_if.lrck_eff;
      if (cap_frame == FRAME_OL1 || cap_frame == FRAME_OL2)
        external_adc_inputs_bclk <= misc_q[MISC_EXT_CLK] ? play_if.bclk_eff : cap_if.bclk_eff;
      else
        external_adc_inputs_bclk <= 1'b0;
    end
  end

  // ==========================================================
  // Misc controls
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      recovered_clock_out    <= 1'b0;
      recovered_clock_out_oe <= 1'b0;
      rolloff_select         <= 1'b0;
      highpass_hold          <= 1'b0;
    end
    else
    begin
      recovered_clock_out    <= recovered_clk_in;
      recovered_clock_out_oe <= !misc_q[MISC_HIZ];
      rolloff_select         <= misc_q[MISC_ROLLOFF];
      highpass_hold          <= misc_q[MISC_HPF];
    end
  end

  // Downstream shadow registers load on the apply pulse only
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      update_hold  <= 1'b0;
      update_apply <= 1'b0;
    end
    else
    begin
      update_hold  <= misc_q[MISC_FREEZE];
      update_apply <= update_hold && !misc_q[MISC_FREEZE];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  ptr_load_a: assert property (ptr_load |=> ptr_r == $past(cp_wdata[6:0]))
    else $error("pointer byte not loaded");
  ptr_step_a: assert property (data_wr && auto_r && !cp_start |=> ptr_r == $past(ptr_r) + 7'h01)
    else $error("pointer did not advance");
  ptr_hold_a: assert property (access && !auto_r |=> $stable(ptr_r))
    else $error("pointer moved without auto-advance");
  id_read_a: assert property (data_rd && ptr_r == ADDR_ID |=> cp_rvalid && cp_rdata == {PART_CODE, REV_CODE})
    else $error("identity byte wrong");
  id_ro_a: assert property (data_wr && ptr_r == ADDR_ID |=> $stable(pwr_q) && $stable(misc_q))
    else $error("write to identity altered state");
  pll_hold_a: assert property (pwr_q[PWR_PLL] |=> pll_hold)
    else $error("PLL not held");
  pair_hold_a: assert property (pwr_q[PWR_PAIR_LO + 2] |=> pair_hold[2])
    else $error("pair not held");
  sleep_all_a: assert property (pwr_q[PWR_GLOBAL] |=> global_sleep && adc_hold && pair_hold == 4'hF)
    else $error("global sleep incomplete");
  deemph_off_a: assert property (!mode_q[MODE_DEEMPH] |=> !deemph_active)
    else $error("de-emphasis without enable");
  cap_frame_a: assert property (fmt_q[FMT_ADC_SL +: 2] == SL_ONE |=> capture_framing == FRAME_OL1)
    else $error("capture framing wrong");
  rsvd_read_a: assert property (data_rd && ptr_r == ADDR_MISC |=> cp_rdata[5] == 1'b0)
    else $error("reserved bit reads one");
  apply_once_a: assert property (update_apply |=> !update_apply ##1 !update_apply)
    else $error("apply pulse too long");

  pwr_write_c: cover property (data_wr && ptr_r == ADDR_PWR ##1 !pwr_q[PWR_GLOBAL]);
  burst_c: cover property (ptr_load ##1 data_wr ##1 data_wr ##1 data_rd);
  apply_c: cover property (update_hold ##[1:20] update_apply);
  master_c: cover property (playback_bclk_oe && capture_bclk_oe);
endmodule : ccr_regs

// ### testbench/ccr_host_model.sv
// Host controller model driving the control port
`timescale 1ns/10ps
module ccr_host_model (
  input  wire logic       sys_clk,
  output logic            cp_start,
  output logic            cp_wr,
  output logic      [7:0] cp_wdata,
  output logic            cp_rd,
  input  wire logic [7:0] cp_rdata,
  input  wire logic       cp_rvalid
);
  initial
  begin
    cp_start = 1'b0;
    cp_wr    = 1'b0;
    cp_wdata = 8'h00;
    cp_rd    = 1'b0;
  end

  // ==========================================================
  // Byte strobes, held across one sampling edge
  task automatic wr(input logic [7:0] b, input logic s);
    @(posedge sys_clk);
    cp_start <= s;
    cp_wr    <= 1'b1;
    cp_wdata <= b;
    @(posedge sys_clk);
    cp_start <= 1'b0;
    cp_wr    <= 1'b0;
    // Released bus shows junk, not the last byte
    cp_wdata <= ~b;
  endtask : wr

  task automatic rd(output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    cp_rd <= 1'b1;
    @(posedge sys_clk);
    cp_rd <= 1'b0;
    #1;
    d = cp_rdata;
    v = cp_rvalid;
  endtask : rd
endmodule : ccr_host_model

// ### testbench/codec_config_registers_test.sv
// Self-checking bench for the codec configuration register bank
`timescale 1ns/10ps
module codec_config_registers_test;
  import ccr_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, force_lock = 1'b0, recovered_clk_in = 1'b0;
  logic [1:0] detected_rate = 2'h0, deemphasis_rate = 2'h0, rate;
  logic cp_start, cp_wr, cp_rd, cp_rvalid, pll_hold, adc_hold, global_sleep;
  logic rolloff_select, highpass_hold, update_hold, recovered_clock_out_oe, deemph_active;
  logic [7:0] cp_wdata, cp_rdata, x, p;
  logic [3:0] pair_hold;
  logic [1:0] dac_port_speed, adc_port_speed, deemph_rate_sel;
  logic playback_rj16, capture_rj16, playback_bclk_oe, capture_bclk_oe, recovered_clock_out, update_apply, ext_bclk;
  ccr_frame_t playback_framing, capture_framing;
  int fails = 0, comparisons = 0, ptr = 1, inc = 1;
  int mem [0:7] = '{0, 8'h52, 8'h01, 8'h00, 8'h40, 8'h03, 0, 0};
  int msk [0:7] = '{0, 0, PWR_MASK, MODE_MASK, FMT_MASK, MISC_MASK, 0, 0};
  int unsigned seed = 50673;

  ccr_host_model ccr_host_model_inst (.sys_clk(sys_clk), .cp_start(cp_start), .cp_wr(cp_wr),
    .cp_wdata(cp_wdata), .cp_rd(cp_rd), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid));

  ccr_regs ccr_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cp_start(cp_start), .cp_wr(cp_wr),
    .cp_wdata(cp_wdata), .cp_rd(cp_rd), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid),
    .detected_rate(detected_rate), .force_lock(force_lock), .deemphasis_rate(deemphasis_rate),
    .recovered_clk_in(recovered_clk_in), .playback_bclk_in(1'b0), .playback_lrck_in(1'b0),
    .capture_bclk_in(1'b0), .capture_lrck_in(1'b0), .playback_bclk_o(), .playback_bclk_oe(playback_bclk_oe),
    .playback_lrck_o(), .playback_lrck_oe(), .capture_bclk_o(), .capture_bclk_oe(capture_bclk_oe),
    .capture_lrck_o(), .capture_lrck_oe(), .capture_shift_bclk(), .capture_shift_lrck(),
    .external_adc_inputs_bclk(ext_bclk), .recovered_clock_out(recovered_clock_out),
    .recovered_clock_out_oe(recovered_clock_out_oe),
    .pll_hold(pll_hold), .adc_hold(adc_hold), .pair_hold(pair_hold), .global_sleep(global_sleep),
    .dac_port_speed(dac_port_speed), .adc_port_speed(adc_port_speed), .deemph_active(deemph_active),
    .deemph_rate_sel(deemph_rate_sel), .playback_framing(playback_framing), .capture_framing(capture_framing),
    .playback_rj16(playback_rj16), .capture_rj16(capture_rj16), .rolloff_select(rolloff_select),
    .highpass_hold(highpass_hold), .update_hold(update_hold), .update_apply(update_apply));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic int fr(int s, int l);
    return (l != 0) ? l + 2 : s;
  endfunction : fr

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic put(input logic [7:0] b, input logic s);
    ccr_host_model_inst.wr(b, s);
    if (s)
    begin
      ptr = b[6:0];
      inc = b[7];
    end
    else
    begin
      // Only the four writable bytes take data; identity and holes ignore it
      if (ptr >= 2 && ptr <= 5) mem[ptr] = b & msk[ptr];
      if (inc != 0) ptr = (ptr + 1) % 128;
    end
  endtask : put

  task automatic get();
    logic [7:0] d;
    logic       v;
    ccr_host_model_inst.rd(d, v);
    chk(v, 8'h01);
    chk(d, mem[ptr]);
    if (inc != 0) ptr = (ptr + 1) % 128;
  endtask : get

  task automatic tally_and_finish();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Clock, watchdog, sequence
  initial forever #20 sys_clk = ~sys_clk;

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(global_sleep, 8'h01);
    chk(pair_hold, 8'h0F);
    repeat (5) get();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      x = rnd();
      detected_rate <= x[1:0];
      force_lock <= x[2];
      deemphasis_rate <= x[4:3];
      recovered_clk_in <= x[5];
      p = rnd() & 8'h7E;
      put(8'h02, 1'b1);
      // Sleep bits move only while the whole part sleeps
      put(p | 8'h01, 1'b0);
      put(p, 1'b0);
      put(8'h83, 1'b1);
      // No reserved speed or framing codes from the host
      // Even passes reach quad speed, right-justified and one-line 2
      put(rnd() & (i[0] ? 8'h56 : 8'hA6), 1'b0);
      put(rnd() & (i[0] ? 8'h55 : 8'hA9), 1'b0);
      put(rnd(), 1'b0);
      put(8'h01, 1'b1);
      put(rnd(), 1'b0);
      put(8'h86, 1'b1);
      put(rnd(), 1'b0);
      put(8'h81, 1'b1);
      repeat (5) get();
      rate = force_lock ? deemphasis_rate : detected_rate;
      chk(pll_hold, mem[2][6]);
      chk(adc_hold, mem[2][5]);
      chk(pair_hold, mem[2][4:1]);
      chk(global_sleep, 8'h00);
      chk(dac_port_speed, mem[3][7:6]);
      chk(adc_port_speed, mem[3][5:4]);
      chk(deemph_active, mem[3][1] && rate != 2'h0);
      chk(playback_framing, fr(mem[4][7:6], mem[4][3:2]));
      chk(capture_framing, fr(mem[4][7:6], mem[4][5:4]));
      chk(recovered_clock_out_oe, !mem[5][6]);
      chk(update_hold, mem[5][4]);
      chk(rolloff_select, mem[5][3]);
      chk(highpass_hold, mem[5][2]);
      chk(deemph_rate_sel, mem[3][1] ? rate : 2'h0);
      chk(playback_rj16, mem[4][0] && fr(mem[4][7:6], mem[4][3:2]) == 2);
      chk(capture_rj16, mem[4][0] && fr(mem[4][7:6], mem[4][5:4]) == 2);
      chk(playback_bclk_oe, mem[5][1]);
      chk(capture_bclk_oe, mem[5][0]);
      chk(recovered_clock_out, x[5]);
      chk(update_apply, 8'h00);
      if (mem[4][5:4] == 0) chk(ext_bclk, 8'h00);
    end
    tally_and_finish();
  end
endmodule : codec_config_registers_test
